/* design/dosc_clock_select.v */
// CPU clock source and division select with oscillator stop control.
// Assumes oscillator levels arrive on pins far slower than i_clock; clocks are
// delivered as one-cycle enable pulses on i_clock rather than as gated clocks.
// Control fields are plain ports; the status bit and bit 3 ignore writes.
`timescale 1ns/1ps
`include "dosc_regs.vh"

module dosc_clock_select (
    input wire i_clock,
    input wire i_sys_rst,
    input wire i_main_osc_in,
    input wire i_sub_osc_in,
    input wire i_reg_wr,
    input wire [7:0] i_reg_wdata,
    input wire i_stop_req,
    input wire i_halt_req,
    output wire [7:0] o_reg_rdata,
    output wire o_main_osc_en,
    output wire o_sub_feedback_disable,
    output wire o_cpu_clk_en,
    output wire o_periph_clk_en,
    output wire o_watch_clk_en,
    output wire o_wdt_count_en,
    output wire o_switch_pending
);
    // Synchronised oscillator levels and their edge history
    wire main_sync;
    wire sub_sync;
    reg main_d_r;
    reg sub_d_r;

    // Fields as software last wrote them
    reg main_osc_stop_r;
    reg sub_feedback_disable_r;
    reg clock_source_select_r;
    reg [2:0] cpu_div_sel_r;

    // Selection the CPU actually runs on; lags the fields by the switchover delay
    reg active_css_r;
    reg [2:0] active_div_r;

    // Rate division and instruction phase
    reg [3:0] div_cnt_r;
    reg sub_phase_r;
    reg instr_phase_r;

    // Switchover wait, counted in instructions of the old clock
    reg pending_r;
    reg [4:0] delay_r;
    reg pending_nxt;
    reg [4:0] delay_nxt;
    reg swap_now;

    // Combinational helpers
    reg [3:0] div_limit;
    reg [2:0] div_clamp;
    reg [4:0] delay_load;
    wire main_edge;
    wire sub_edge;
    wire main_tick;
    wire cpu_tick;
    wire instr_end;
    wire wr_change;

    dosc_sync u_main_sync (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_async(i_main_osc_in),
        .o_sync(main_sync)
    );
    dosc_sync u_sub_sync (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_async(i_sub_osc_in),
        .o_sync(sub_sync)
    );

    // Stop instruction only acts on main clock; stop bit only once the subclock runs
    assign o_main_osc_en = ~i_sys_rst & ~(i_stop_req & ~active_css_r)
        & ~(main_osc_stop_r & clock_source_select_r & active_css_r);
    // Rising edges of the synchronised levels are the oscillator ticks
    assign main_edge = main_sync & ~main_d_r;
    assign sub_edge = sub_sync & ~sub_d_r;
    assign main_tick = main_edge & o_main_osc_en;

    // Codes above the slowest run as the slowest division
    always @* begin
        div_clamp = (active_div_r > `DOSC_DIV_SLOWEST) ? `DOSC_DIV_SLOWEST : active_div_r;
        div_limit = (4'h1 << div_clamp) - 4'h1;
        if (active_css_r) begin
            delay_load = `DOSC_DELAY_SUB;
        end else begin
            delay_load = `DOSC_DELAY_FASTEST >> div_clamp;
        end
    end

    // Subsystem CPU clock is a fixed half of the subclock, divider ignored
    assign cpu_tick = active_css_r ? (sub_edge & sub_phase_r)
        : (main_tick & (div_cnt_r == div_limit));
    assign instr_end = cpu_tick & instr_phase_r;
    assign o_cpu_clk_en = cpu_tick & ~i_halt_req;
    assign o_periph_clk_en = main_tick;
    assign o_watch_clk_en = sub_edge;
    assign o_wdt_count_en = main_tick & ~active_css_r;
    assign o_sub_feedback_disable = sub_feedback_disable_r;
    assign o_switch_pending = pending_r;
    // Bit 3 always reads 0; the status shows the running source, not the request
    assign o_reg_rdata = {main_osc_stop_r, sub_feedback_disable_r, active_css_r,
        clock_source_select_r, 1'b0, cpu_div_sel_r};
    // Only a change of source or division starts a wait
    assign wr_change = i_reg_wr & ((i_reg_wdata[`DOSC_BIT_CLOCK_SOURCE_SELECT] != clock_source_select_r)
        | (i_reg_wdata[`DOSC_DIV_MSB:0] != cpu_div_sel_r));

    // Reset image split into fields so each register loads its own slice
    localparam [7:0] CTRL_RESET = `DOSC_CTRL_RESET;

    // Edge detectors start low like the synchronisers, so reset gives no false edge
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            main_d_r <= 1'b0;
            sub_d_r <= 1'b0;
        end else begin
            main_d_r <= main_sync;
            sub_d_r <= sub_sync;
        end
    end

    // Control register; status and bit 3 are not writable
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            main_osc_stop_r <= CTRL_RESET[`DOSC_BIT_MAIN_OSC_STOP];
            sub_feedback_disable_r <= CTRL_RESET[`DOSC_BIT_SUB_FEEDBACK_DISABLE];
            clock_source_select_r <= CTRL_RESET[`DOSC_BIT_CLOCK_SOURCE_SELECT];
            cpu_div_sel_r <= CTRL_RESET[`DOSC_DIV_MSB:0];
        end else if (i_reg_wr) begin
            main_osc_stop_r <= i_reg_wdata[`DOSC_BIT_MAIN_OSC_STOP];
            sub_feedback_disable_r <= i_reg_wdata[`DOSC_BIT_SUB_FEEDBACK_DISABLE];
            clock_source_select_r <= i_reg_wdata[`DOSC_BIT_CLOCK_SOURCE_SELECT];
            cpu_div_sel_r <= i_reg_wdata[`DOSC_DIV_MSB:0];
        end
    end

    // Delay counted in old-clock instructions; a second write keeps the count running
    always @* begin
        pending_nxt = pending_r;
        delay_nxt = delay_r;
        swap_now = 1'b0;
        if (wr_change & ~pending_r) begin
            pending_nxt = 1'b1;
            delay_nxt = delay_load;
        end else if (pending_r & instr_end) begin
            if (delay_r <= 5'h01) begin
                // Swapping on the tick keeps every CPU period whole
                pending_nxt = 1'b0;
                swap_now = 1'b1;
            end else begin
                delay_nxt = delay_r - 5'h01;
            end
        end
    end

    // Pending flag and instruction count
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            pending_r <= 1'b0;
            delay_r <= 5'h00;
        end else begin
            pending_r <= pending_nxt;
            delay_r <= delay_nxt;
        end
    end

    // Active selection moves only on an instruction-ending tick
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            active_css_r <= 1'b0;
            active_div_r <= `DOSC_DIV_SLOWEST;
        end else if (swap_now) begin
            active_css_r <= clock_source_select_r;
            active_div_r <= cpu_div_sel_r;
        end
    end

    // Divider, subclock phase and instruction phase restart together at a swap
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            div_cnt_r <= 4'h0;
            sub_phase_r <= 1'b0;
            instr_phase_r <= 1'b0;
        end else if (swap_now) begin
            div_cnt_r <= 4'h0;
            sub_phase_r <= 1'b0;
            instr_phase_r <= 1'b0;
        end else begin
            if (main_tick & ~active_css_r) begin
                div_cnt_r <= (div_cnt_r == div_limit) ? 4'h0 : div_cnt_r + 4'h1;
            end
            if (sub_edge & active_css_r) begin
                sub_phase_r <= ~sub_phase_r;
            end
            if (cpu_tick) begin
                instr_phase_r <= ~instr_phase_r;
            end
        end
    end
endmodule // dosc_clock_select

/* design/dosc_regs.vh */
// Constants for the dual oscillator CPU clock select block.
// Assumes a single 100 MHz system clock and plain-port control access.
`ifndef DOSC_REGS_VH
`define DOSC_REGS_VH
`define DOSC_BIT_MAIN_OSC_STOP 7
`define DOSC_BIT_SUB_FEEDBACK_DISABLE 6
`define DOSC_BIT_CLOCK_SOURCE_STATUS 5
`define DOSC_BIT_CLOCK_SOURCE_SELECT 4
`define DOSC_BIT_RESERVED 3
`define DOSC_DIV_MSB 2
`define DOSC_CTRL_RESET 8'h04
`define DOSC_DIV_SLOWEST 3'h4
`define DOSC_DELAY_FASTEST 5'h10
`define DOSC_DELAY_SUB 5'h01
`define DOSC_SUB_CPU_DIV_LOG2 1
`endif

/* design/dosc_sync.v */
// Two flip-flop synchroniser for one level.
// Assumes the input is asynchronous to i_clock.
`timescale 1ns/1ps
module dosc_sync (
    input wire i_clock,
    input wire i_sys_rst,
    input wire i_async,
    output wire o_sync
);
    reg meta_r;
    reg sync_r;
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end
    assign o_sync = sync_r;
endmodule // dosc_sync

/* verif/dosc_chk_monitor.sv */
// Assertions on the ports of the clock select block.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module dosc_chk (
    input wire i_clock,
    input wire i_sys_rst,
    input wire i_reg_wr,
    input wire [7:0] i_reg_wdata,
    input wire i_stop_req,
    input wire [7:0] o_reg_rdata,
    input wire o_main_osc_en,
    input wire o_sub_feedback_disable,
    input wire o_periph_clk_en,
    input wire o_wdt_count_en,
    input wire o_switch_pending
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    a_osc_in_reset: assert property (disable iff (1'b0) i_sys_rst |-> !o_main_osc_en) else $error("osc ran in reset");
    a_reset_value: assert property ($fell(i_sys_rst) |-> o_reg_rdata == 8'h04) else $error("bad reset value");
    a_fb_follows: assert property (i_reg_wr |=> o_sub_feedback_disable == $past(i_reg_wdata[6])) else $error("fb bit");
    a_bit3_zero: assert property (o_reg_rdata[3] == 1'b0) else $error("bit 3 set");
    a_osc_stop_cause: assert property (!o_main_osc_en |-> (o_reg_rdata[7] && o_reg_rdata[5:4] == 2'b11)
        || (i_stop_req && !o_reg_rdata[5])) else $error("osc stopped without cause");
    a_wdt_on_sub: assert property (o_reg_rdata[5] |-> !o_wdt_count_en) else $error("wdt counts on sub");
    a_periph_stop: assert property (!o_main_osc_en ##1 !o_main_osc_en |-> !o_periph_clk_en) else $error("periph");
    a_status_moves: assert property ($changed(o_reg_rdata[5]) |-> $past(o_switch_pending)) else $error("status");
    a_pending_set: assert property (i_reg_wr && !o_switch_pending
        && {i_reg_wdata[4], i_reg_wdata[2:0]} != {o_reg_rdata[4], o_reg_rdata[2:0]} |=> o_switch_pending)
        else $error("no pending");
endmodule // dosc_chk
bind dosc_clock_select dosc_chk dosc_chk_inst (.*);

/* verif/dosc_osc_model.sv */
// Crystal-style oscillator pair feeding the block's oscillator pins.
// Assumes main period 8 and sub period 64 system clocks.
`timescale 1ns/1ps
module dosc_osc_model (
    input wire i_clock,
    input wire i_main_en,
    output logic o_main,
    output logic o_sub
);
    logic [5:0] cnt_r = 6'h00;
    initial o_main = 1'b0;
    initial o_sub = 1'b0;
    always @(posedge i_clock) begin
        cnt_r <= cnt_r + 6'h01;
        o_sub <= cnt_r[5];
        // Resonator, not external clock, so stopping it is legal
        o_main <= i_main_en ? cnt_r[2] : 1'b0;
    end
endmodule // dosc_osc_model

/* verif/dosc_clock_select_tb_top.sv */
// Self-checking bench for the clock select block.
// Assumes oscillator levels from dosc_osc_model and a 100 MHz clock.
`timescale 1ns/1ps
module dosc_clock_select_tb_top;
    logic i_clock = 0, i_sys_rst = 1, i_reg_wr = 0, i_stop_req = 0, i_halt_req = 0;
    logic [7:0] i_reg_wdata = 8'h00, o_reg_rdata;
    logic mo, so, oe, fb, ce, pe, we, de, sp;
    int errors = 0, total_checks = 0, n;
    dosc_osc_model dosc_osc_model_inst (.i_clock(i_clock), .i_main_en(oe), .o_main(mo), .o_sub(so));
    dosc_clock_select dosc_clock_select_inst (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_main_osc_in(mo),
        .i_sub_osc_in(so), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_stop_req(i_stop_req),
        .i_halt_req(i_halt_req), .o_reg_rdata(o_reg_rdata), .o_main_osc_en(oe), .o_sub_feedback_disable(fb),
        .o_cpu_clk_en(ce), .o_periph_clk_en(pe), .o_watch_clk_en(we), .o_wdt_count_en(de), .o_switch_pending(sp));
    initial forever #5 i_clock = ~i_clock;
    task chk(input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] d);
        @(posedge i_clock) i_reg_wr <= 1;
        i_reg_wdata <= d;
        @(posedge i_clock) i_reg_wr <= 0;
        #1;
    endtask
    task wait_sw(output int c);
        c = 0;
        while (sp !== 1'b0 && c < 5000) begin
            @(posedge i_clock) #1;
            c++;
        end
        if (sp !== 1'b0) errors++;
    endtask
    task gap(output int c);
        @(posedge i_clock iff ce);
        c = 0;
        do begin
            @(posedge i_clock);
            c++;
        end while (!ce && c < 2000);
        #1;
    endtask
    task t_div;
        for (int d = 0; d < 5; d++) begin
            wr(8'(d));
            wait_sw(n);
            gap(n);
            chk(8'(n), 8'(8 << d));
        end
    endtask
    task t_dly;
        wr(8'h00);
        wait_sw(n);
        wr(8'h04);
        wait_sw(n);
        chk(8'(n >= 230 && n <= 262), 8'h01);
        n = 0;
        repeat (64) @(posedge i_clock) n += pe + de + 16 * we;
        chk(8'(n), 8'h20);
    endtask
    task t_misc;
        wr(8'h64);
        chk(o_reg_rdata, 8'h44);
        chk(8'(fb), 8'h01);
        @(posedge i_clock) i_stop_req <= 1;
        @(posedge i_clock) #1;
        chk(8'(oe), 8'h00);
        @(posedge i_clock) i_stop_req <= 0;
        wr(8'h04);
        @(posedge i_clock) i_halt_req <= 1;
        n = 0;
        repeat (140) @(posedge i_clock) n += ce;
        chk(8'(n), 8'h00);
        @(posedge i_clock) i_halt_req <= 0;
    endtask
    task t_sub;
        wr(8'h84);
        chk(8'(oe), 8'h01);
        wr(8'h94);
        wait_sw(n);
        chk(o_reg_rdata, 8'hb4);
        chk(8'(oe), 8'h00);
        n = 0;
        repeat (60) @(posedge i_clock) n += pe + de;
        chk(8'(n), 8'h00);
        wr(8'h12);
        @(posedge i_clock) i_stop_req <= 1;
        gap(n);
        chk(8'(n), 8'h80);
        chk(8'(oe), 8'h01);
        @(posedge i_clock) i_stop_req <= 0;
        wr(8'h00);
        wait_sw(n);
        chk(o_reg_rdata, 8'h00);
    endtask
    task wrap_up;
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge i_clock);
        #1;
        chk(o_reg_rdata, 8'h04);
        chk(8'(oe), 8'h00);
        @(posedge i_clock) i_sys_rst <= 0;
        t_div;
        t_dly;
        t_misc;
        t_sub;
        wrap_up;
    end
    initial begin
        #200000;
        errors++;
        wrap_up;
    end
endmodule // dosc_clock_select_tb_top
